/* logic/hpp_device.sv */
// Purpose: device end of the byte-wide host parallel port, core bank and host bank
// Assumes: one clock; pin levels are synchronous to core_clk
// Notes: core registers at word index 0..7, host registers at byte address 0..7
// What this block does
// - byte-wide full-duplex double-buffered parallel port
// - host bank and core bank kept apart
// - each bank reachable only from its own side
// - eight consecutive core word locations
// - core moves 24-bit words only
// - eight consecutive host byte addresses
// - host moves bytes, assembled into core words
// - host command raises a core interrupt
// - host may poll, take interrupts or DMA
// - separate request line per source
// - muxed mode shares data pins with address
// - one pin is address strobe or A0
// - chip select or high address lines
// - single strobe or dual read/write strobes
// - vectored request/ack or separate request lines
// - disabled port leaves sixteen GPIO bits
// - five pins may become GPIO in use
// - fixed GPIO bit numbering of pins
// - host bytes load core receive word
// - core transmit word loads host bytes
// - reset disables port, pins disconnected GPIO
`default_nettype none
`include "hpp_defs.svh"
module hpp_device (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [2:0] coreAddr,
  input wire logic coreWr,
  input wire logic coreRd,
  input wire logic [23:0] coreWdata,
  output logic [23:0] coreRdata,
  output logic coreRxIrq,
  output logic coreTxIrq,
  output logic coreCmdIrq,
  output logic [6:0] coreCmdVec,
  hpp_if.dev pins
);
  import hpp_pkg::*;
  logic [4:0] hcr_q, hcr_d, icr_q, icr_d;
  logic [8:0] port_pin_control_reg_q, port_pin_control_reg_d;
  logic [7:0] base_address_reg_q, base_address_reg_d, ivr_q, ivr_d, addrLat_q, addrLat_d;
  logic [15:0] gpio_direction_reg_q, gpio_direction_reg_d, hdr_q, hdr_d, padOut_q, padOut_d, padOe_q, padOe_d;
  logic [23:0] core_receive_reg_q, core_receive_reg_d, core_transmit_reg_q, core_transmit_reg_d, tx_q, tx_d, rx_q, rx_d, crd_q, crd_d;
  logic [6:0] cvr_q, cvr_d;
  logic core_rx_full_flag_q, core_rx_full_flag_d, core_tx_empty_flag_q, core_tx_empty_flag_d, hcp_q, hcp_d, host_tx_empty_flag_q, host_tx_empty_flag_d, host_rx_full_flag_q, host_rx_full_flag_d;
  logic h2cWait_q, h2cWait_d, c2hWait_q, c2hWait_d, strbPrev_q, asPrev_q;
  logic txdeS1_q, txdeS2_q, rxdfS1_q, rxdfS2_q, hrdfS1_q, hrdfS2_q;
  logic irqRx_q, irqTx_q, irqCmd_q;
  logic [15:0] lvl, gpioSel, ifOut, ifOe;
  logic en, mux, dual, novec, rdAct, wrAct, sel, strbRise, hostWr, hostRd, ackRd, asFall;
  logic rxReq, txReq;
  logic [2:0] hAddr;
  logic [7:0] rdByte, stat;
  logic [23:0] cval;

  assign lvl = pins.padLevel;
  assign en = port_pin_control_reg_q[`HPP_PC_EN];
  assign mux = port_pin_control_reg_q[`HPP_PC_MUX];
  assign dual = port_pin_control_reg_q[`HPP_PC_DUAL];
  assign novec = port_pin_control_reg_q[`HPP_PC_NOVEC];
  // strobe decode: RW/DS or RD/WR on the same two pins
  assign rdAct = dual ? ~lvl[`HPP_PIN_RW] : (~lvl[`HPP_PIN_DS] & lvl[`HPP_PIN_RW]);
  assign wrAct = dual ? ~lvl[`HPP_PIN_DS] : (~lvl[`HPP_PIN_DS] & ~lvl[`HPP_PIN_RW]);
  // muxed mode latches the address off the data pins on the strobe's falling edge
  assign asFall = mux & ~lvl[`HPP_PIN_AS] & asPrev_q;
  assign hAddr = mux ? addrLat_q[2:0] :
                 {lvl[`HPP_PIN_A2], lvl[`HPP_PIN_A1], lvl[`HPP_PIN_AS]};
  assign sel = en & (mux ? (addrLat_q[7:3] == base_address_reg_q[4:0]) : ~lvl[`HPP_PIN_CS]);
  assign strbRise = (rdAct | wrAct) & ~strbPrev_q;
  assign hostWr = sel & wrAct & strbRise;
  assign hostRd = sel & rdAct & strbRise;
  assign rxReq = icr_q[`HPP_IC_RREQ] & host_rx_full_flag_q;
  assign txReq = icr_q[`HPP_IC_TREQ] & host_tx_empty_flag_q;

  // pins that software has handed back to GPIO; all of them while disabled
  always_comb begin
    gpioSel = 16'hffff;
    if (en) begin
      gpioSel = 16'h0000;
      gpioSel[`HPP_PIN_A1] = mux & port_pin_control_reg_q[`HPP_PC_GA8];
      gpioSel[`HPP_PIN_A2] = mux & port_pin_control_reg_q[`HPP_PC_GA9];
      gpioSel[`HPP_PIN_CS] = mux & port_pin_control_reg_q[`HPP_PC_GA10];
      gpioSel[`HPP_PIN_REQ] = port_pin_control_reg_q[`HPP_PC_GREQ];
      gpioSel[`HPP_PIN_ACK] = port_pin_control_reg_q[`HPP_PC_GACK];
    end
  end
  assign ackRd = en & ~novec & ~gpioSel[`HPP_PIN_ACK] & ~lvl[`HPP_PIN_ACK];

  always_comb begin
    stat = 8'h00;
    stat[`HPP_IS_HOST_RX_FULL_FLAG] = host_rx_full_flag_q;
    stat[`HPP_IS_HOST_TX_EMPTY_FLAG] = host_tx_empty_flag_q;
    stat[`HPP_IS_TRDY] = host_tx_empty_flag_q & ~hrdfS2_q;
    stat[`HPP_IS_F2] = hcr_q[`HPP_CC_F2];
    stat[`HPP_IS_F3] = hcr_q[`HPP_CC_F3];
    stat[`HPP_IS_REQ] = rxReq | txReq;
    case (hAddr)
      `HPP_H_CTRL: rdByte = {3'h0, icr_q};
      `HPP_H_CMDVEC: rdByte = {hcp_q, cvr_q};
      `HPP_H_STAT: rdByte = stat;
      `HPP_H_IRQVEC: rdByte = ivr_q;
      `HPP_H_HIGH: rdByte = rx_q[23:16];
      `HPP_H_MID: rdByte = rx_q[15:8];
      `HPP_H_LOW: rdByte = rx_q[7:0];
      default: rdByte = 8'h00;
    endcase
    if (ackRd) begin
      rdByte = ivr_q;
    end
  end

  // pin drive of the interface itself
  always_comb begin
    ifOut = 16'hffff;
    ifOe = 16'h0000;
    ifOut[7:0] = rdByte;
    ifOe[7:0] = {8{(sel & rdAct) | ackRd}};
    if (novec) begin
      ifOut[`HPP_PIN_REQ] = ~txReq;
      ifOut[`HPP_PIN_ACK] = ~rxReq;
      ifOe[`HPP_PIN_ACK] = 1'b1;
    end else begin
      ifOut[`HPP_PIN_REQ] = ~(txReq | rxReq);
    end
    ifOe[`HPP_PIN_REQ] = 1'b1;
  end

  always_comb begin
    case (coreAddr)
      `HPP_C_CTRL: cval = {19'h0, hcr_q};
      `HPP_C_STAT: cval = {19'h0, icr_q[`HPP_IC_F1], icr_q[`HPP_IC_F0], hcp_q, core_tx_empty_flag_q, core_rx_full_flag_q};
      `HPP_C_GDIR: cval = {8'h0, gpio_direction_reg_q};
      `HPP_C_GVAL: cval = {8'h0, (gpio_direction_reg_q & hdr_q) | (~gpio_direction_reg_q & lvl)};
      `HPP_C_BASE: cval = {16'h0, base_address_reg_q};
      `HPP_C_PINS: cval = {15'h0, port_pin_control_reg_q};
      `HPP_C_RX: cval = core_receive_reg_q;
      default: cval = 24'h000000;
    endcase
  end

  always_comb begin
    hcr_d = hcr_q;
    port_pin_control_reg_d = port_pin_control_reg_q;
    base_address_reg_d = base_address_reg_q;
    gpio_direction_reg_d = gpio_direction_reg_q;
    hdr_d = hdr_q;
    core_transmit_reg_d = core_transmit_reg_q;
    core_receive_reg_d = core_receive_reg_q;
    core_rx_full_flag_d = core_rx_full_flag_q;
    core_tx_empty_flag_d = core_tx_empty_flag_q;
    hcp_d = hcp_q;
    icr_d = icr_q;
    cvr_d = cvr_q;
    ivr_d = ivr_q;
    tx_d = tx_q;
    rx_d = rx_q;
    host_tx_empty_flag_d = host_tx_empty_flag_q;
    host_rx_full_flag_d = host_rx_full_flag_q;
    addrLat_d = asFall ? lvl[7:0] : addrLat_q;
    crd_d = coreRd ? cval : crd_q;
    h2cWait_d = h2cWait_q & ~txdeS2_q;
    c2hWait_d = c2hWait_q & ~rxdfS2_q;
    if (coreWr) begin
      case (coreAddr)
        `HPP_C_CTRL: hcr_d = coreWdata[4:0];
        `HPP_C_STAT: hcp_d = hcp_q & ~coreWdata[`HPP_CS_CMDPEND];
        `HPP_C_GDIR: gpio_direction_reg_d = coreWdata[15:0];
        `HPP_C_GVAL: hdr_d = coreWdata[15:0];
        `HPP_C_BASE: base_address_reg_d = coreWdata[7:0];
        `HPP_C_PINS: port_pin_control_reg_d = coreWdata[8:0];
        `HPP_C_TX: begin
          core_transmit_reg_d = coreWdata;
          core_tx_empty_flag_d = 1'b0;
        end
        default: hcr_d = hcr_q;
      endcase
    end
    if (coreRd && coreAddr == `HPP_C_RX) begin
      core_rx_full_flag_d = 1'b0;
    end
    if (hostWr) begin
      case (hAddr)
        `HPP_H_CTRL: icr_d = lvl[4:0];
        `HPP_H_CMDVEC: cvr_d = lvl[6:0];
        `HPP_H_IRQVEC: ivr_d = lvl[7:0];
        `HPP_H_HIGH: tx_d[23:16] = lvl[7:0];
        `HPP_H_MID: tx_d[15:8] = lvl[7:0];
        `HPP_H_LOW: begin
          tx_d[7:0] = lvl[7:0];
          host_tx_empty_flag_d = 1'b0;
        end
        default: icr_d = icr_q;
      endcase
    end
    if (hostRd && hAddr == `HPP_H_LOW) begin
      host_rx_full_flag_d = 1'b0;
    end
    // hardware sets come last so a set in the clearing cycle survives
    if (hostWr && hAddr == `HPP_H_CMDVEC && lvl[`HPP_CV_CMD]) begin
      hcp_d = 1'b1;
    end
    // the wait flags stop a second move before the synchronised flag catches up
    if (!txdeS2_q && !h2cWait_q && !core_rx_full_flag_q) begin
      core_receive_reg_d = tx_q;
      core_rx_full_flag_d = 1'b1;
      host_tx_empty_flag_d = 1'b1;
      h2cWait_d = 1'b1;
    end
    if (!core_tx_empty_flag_q && !rxdfS2_q && !c2hWait_q) begin
      rx_d = core_transmit_reg_q;
      host_rx_full_flag_d = 1'b1;
      core_tx_empty_flag_d = 1'b1;
      c2hWait_d = 1'b1;
    end
    padOut_d = (gpioSel & hdr_q) | (~gpioSel & ifOut);
    padOe_d = (gpioSel & gpio_direction_reg_q) | (~gpioSel & ifOe);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hcr_q <= 5'h00;
      port_pin_control_reg_q <= 9'h000;
      base_address_reg_q <= 8'h00;
      gpio_direction_reg_q <= 16'h0000;
      hdr_q <= 16'h0000;
      core_transmit_reg_q <= 24'h000000;
      core_receive_reg_q <= 24'h000000;
      core_rx_full_flag_q <= 1'b0;
      core_tx_empty_flag_q <= 1'b1;
      hcp_q <= 1'b0;
      icr_q <= 5'h00;
      cvr_q <= 7'h00;
      ivr_q <= `HPP_IVR_RST;
      tx_q <= 24'h000000;
      rx_q <= 24'h000000;
      host_tx_empty_flag_q <= 1'b1;
      host_rx_full_flag_q <= 1'b0;
      addrLat_q <= 8'h00;
      crd_q <= 24'h000000;
      h2cWait_q <= 1'b0;
      c2hWait_q <= 1'b0;
      strbPrev_q <= 1'b0;
      asPrev_q <= 1'b1;
      {txdeS1_q, txdeS2_q, rxdfS1_q, rxdfS2_q, hrdfS1_q, hrdfS2_q} <= 6'b110000;
      padOut_q <= 16'h0000;
      padOe_q <= 16'h0000;
      {irqRx_q, irqTx_q, irqCmd_q} <= 3'b000;
    end else begin
      hcr_q <= hcr_d;
      port_pin_control_reg_q <= port_pin_control_reg_d;
      base_address_reg_q <= base_address_reg_d;
      gpio_direction_reg_q <= gpio_direction_reg_d;
      hdr_q <= hdr_d;
      core_transmit_reg_q <= core_transmit_reg_d;
      core_receive_reg_q <= core_receive_reg_d;
      core_rx_full_flag_q <= core_rx_full_flag_d;
      core_tx_empty_flag_q <= core_tx_empty_flag_d;
      hcp_q <= hcp_d;
      icr_q <= icr_d;
      cvr_q <= cvr_d;
      ivr_q <= ivr_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      host_tx_empty_flag_q <= host_tx_empty_flag_d;
      host_rx_full_flag_q <= host_rx_full_flag_d;
      addrLat_q <= addrLat_d;
      crd_q <= crd_d;
      h2cWait_q <= h2cWait_d;
      c2hWait_q <= c2hWait_d;
      strbPrev_q <= rdAct | wrAct;
      asPrev_q <= lvl[`HPP_PIN_AS];
      txdeS1_q <= host_tx_empty_flag_q;
      txdeS2_q <= txdeS1_q;
      rxdfS1_q <= host_rx_full_flag_q;
      rxdfS2_q <= rxdfS1_q;
      hrdfS1_q <= core_rx_full_flag_q;
      hrdfS2_q <= hrdfS1_q;
      padOut_q <= padOut_d;
      padOe_q <= padOe_d;
      irqRx_q <= hcr_q[`HPP_CC_RXIE] & core_rx_full_flag_q;
      irqTx_q <= hcr_q[`HPP_CC_TXIE] & core_tx_empty_flag_q;
      irqCmd_q <= hcr_q[`HPP_CC_CMDIE] & hcp_q;
    end
  end

  assign coreRdata = crd_q;
  assign coreRxIrq = irqRx_q;
  assign coreTxIrq = irqTx_q;
  assign coreCmdIrq = irqCmd_q;
  assign coreCmdVec = cvr_q;
  assign pins.devOut = padOut_q;
  assign pins.devOe = padOe_q;
endmodule // hpp_device
`default_nettype wire

/* logic/hpp_defs.svh */
// Purpose: offsets, field positions, reset values and timing of the host parallel port
// Assumes: included by the device and host design files of the port
// Notes: definitions only
`ifndef HPP_DEFS_SVH
`define HPP_DEFS_SVH
// core bank, word index
`define HPP_C_CTRL 3'h0
`define HPP_C_STAT 3'h1
`define HPP_C_GDIR 3'h2
`define HPP_C_GVAL 3'h3
`define HPP_C_BASE 3'h4
`define HPP_C_PINS 3'h5
`define HPP_C_RX 3'h6
`define HPP_C_TX 3'h7
// host bank, byte address
`define HPP_H_CTRL 3'h0
`define HPP_H_CMDVEC 3'h1
`define HPP_H_STAT 3'h2
`define HPP_H_IRQVEC 3'h3
`define HPP_H_HIGH 3'h5
`define HPP_H_MID 3'h6
`define HPP_H_LOW 3'h7
// core control / status bits
`define HPP_CC_RXIE 0
`define HPP_CC_TXIE 1
`define HPP_CC_CMDIE 2
`define HPP_CC_F2 3
`define HPP_CC_F3 4
`define HPP_CS_RXFULL 0
`define HPP_CS_TXEMPTY 1
`define HPP_CS_CMDPEND 2
`define HPP_CS_F0 3
`define HPP_CS_F1 4
// pin control bits
`define HPP_PC_EN 0
`define HPP_PC_MUX 1
`define HPP_PC_DUAL 2
`define HPP_PC_NOVEC 3
`define HPP_PC_GA8 4
`define HPP_PC_GA9 5
`define HPP_PC_GA10 6
`define HPP_PC_GREQ 7
`define HPP_PC_GACK 8
// host control / status bits
`define HPP_IC_RREQ 0
`define HPP_IC_TREQ 1
`define HPP_IC_F0 3
`define HPP_IC_F1 4
`define HPP_IS_HOST_RX_FULL_FLAG 0
`define HPP_IS_HOST_TX_EMPTY_FLAG 1
`define HPP_IS_TRDY 2
`define HPP_IS_F2 3
`define HPP_IS_F3 4
`define HPP_IS_REQ 7
`define HPP_CV_CMD 7
// pin numbers inside the 16-pin port
`define HPP_PIN_AS 8
`define HPP_PIN_A1 9
`define HPP_PIN_A2 10
`define HPP_PIN_RW 11
`define HPP_PIN_DS 12
`define HPP_PIN_CS 13
`define HPP_PIN_REQ 14
`define HPP_PIN_ACK 15
// reset values
`define HPP_IVR_RST 8'h00
// host strobe timing
`define HPP_CLK_MHZ 40
`define HPP_STROBE_NS 100
`define HPP_STROBE_CYC ((`HPP_STROBE_NS * `HPP_CLK_MHZ + 999) / 1000)
`endif

/* logic/hpp_pkg.sv */
// Purpose: types used by the host end of the host parallel port
// Assumes: nothing
// Notes: timing and offsets live in hpp_defs.svh
`default_nettype none
package hpp_pkg;
  typedef enum logic [1:0] {
    HPP_A_IDLE = 2'b00,
    HPP_A_ADDR = 2'b01,
    HPP_A_STRB = 2'b10,
    HPP_A_GAP = 2'b11
  } hpp_acc_t;
  typedef enum logic [2:0] {
    HPP_J_INIT = 3'b000,
    HPP_J_POLL = 3'b001,
    HPP_J_RX = 3'b010,
    HPP_J_TX = 3'b011,
    HPP_J_CMD = 3'b100
  } hpp_job_t;
endpackage
`default_nettype wire

/* logic/hpp_if.sv */
// Purpose: the sixteen shared pins between host and device
// Assumes: undriven pins are pulled high
// Notes: device drive wins if both ends drive
`default_nettype none
interface hpp_if;
  logic [15:0] devOut;
  logic [15:0] devOe;
  logic [15:0] hostOut;
  logic [15:0] hostOe;
  wire logic [15:0] padLevel;
  assign padLevel = (devOe & devOut) | (~devOe & hostOe & hostOut) | (~devOe & ~hostOe);
  modport dev (output devOut, output devOe, input padLevel);
  modport host (output hostOut, output hostOe, input padLevel);
endinterface
`default_nettype wire

/* logic/hpp_fifo.sv */
// Purpose: word FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty are registered so ready/valid come from flops
`default_nettype none
module hpp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic full_q, full_d, empty_q, empty_d, push, pop;
  assign push = inValid & ~full_q;
  assign pop = outReady & ~empty_q;
  assign inReady = ~full_q;
  assign outValid = ~empty_q;
  assign outData = mem[rdPtr_q];
  always_comb begin
    wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
    rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    full_d = cnt_d == (AW+1)'(DEPTH);
    empty_d = cnt_d == '0;
  end
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q <= cnt_d;
      full_q <= full_d;
      empty_q <= empty_d;
    end
  end
endmodule // hpp_fifo
`default_nettype wire

/* logic/hpp_host.sv */
// Purpose: host end of the byte-wide parallel port, driving the pins by polling
// Assumes: cfg inputs match the device's pin control register
// Notes: words to send queue in a FIFO; it fills while the device is busy
`default_nettype none
`include "hpp_defs.svh"
module hpp_host (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic cfgMux,
  input wire logic cfgDual,
  input wire logic [4:0] cfgBase,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [23:0] wrData,
  output logic rdValid,
  input wire logic rdReady,
  output logic [23:0] rdData,
  input wire logic cmdValid,
  input wire logic [6:0] cmdVector,
  output logic cmdReady,
  hpp_if.host pins
);
  import hpp_pkg::*;
  localparam logic [3:0] STRB_CYC = 4'(`HPP_STROBE_CYC);
  hpp_acc_t acc_q, acc_d;
  hpp_job_t job_q, job_d;
  logic [1:0] step_q, step_d;
  logic [3:0] cnt_q, cnt_d;
  logic [2:0] addr_q, addr_d;
  logic wr_q, wr_d, rdValid_q, rdValid_d, cmdReady_q, cmdReady_d, fifoPop;
  logic [7:0] data_q, data_d, byte_q, byte_d;
  logic [23:0] word_q, word_d, rdData_q, rdData_d, fifoData;
  logic [15:0] out_d, oe_d, out_q, oe_q;
  logic fifoValid, accDone;

  hpp_fifo #(.WIDTH(24), .DEPTH(16)) txFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrData),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  assign accDone = acc_q == HPP_A_GAP;

  always_comb begin
    acc_d = acc_q;
    cnt_d = cnt_q - 4'h1;
    byte_d = byte_q;
    job_d = job_q;
    step_d = step_q;
    addr_d = addr_q;
    wr_d = wr_q;
    data_d = data_q;
    word_d = word_q;
    rdData_d = rdData_q;
    rdValid_d = rdValid_q & ~rdReady;
    cmdReady_d = 1'b0;
    fifoPop = 1'b0;
    case (acc_q)
      HPP_A_ADDR: if (cnt_q == 4'h1) begin
        acc_d = HPP_A_STRB;
        cnt_d = STRB_CYC;
      end
      HPP_A_STRB: if (cnt_q == 4'h1) begin
        acc_d = HPP_A_GAP;
        byte_d = pins.padLevel[7:0];
      end
      default: acc_d = HPP_A_IDLE;
    endcase
    // one byte access per step; the access engine idles while the job decides
    if (acc_q == HPP_A_IDLE) begin
      acc_d = cfgMux ? HPP_A_ADDR : HPP_A_STRB;
      cnt_d = STRB_CYC;
      case (job_q)
        HPP_J_INIT: begin
          addr_d = `HPP_H_CTRL;
          wr_d = 1'b1;
          data_d = 8'h00;
          data_d[`HPP_IC_RREQ] = 1'b1;
          data_d[`HPP_IC_TREQ] = 1'b1;
        end
        HPP_J_POLL: begin
          addr_d = `HPP_H_STAT;
          wr_d = 1'b0;
        end
        HPP_J_RX: begin
          addr_d = `HPP_H_HIGH + {1'b0, step_q};
          wr_d = 1'b0;
        end
        HPP_J_TX: begin
          addr_d = `HPP_H_HIGH + {1'b0, step_q};
          wr_d = 1'b1;
          data_d = step_q == 2'h0 ? word_q[23:16] : (step_q == 2'h1 ? word_q[15:8] : word_q[7:0]);
        end
        HPP_J_CMD: begin
          addr_d = `HPP_H_CMDVEC;
          wr_d = 1'b1;
          data_d = {1'b1, cmdVector};
        end
        default: acc_d = HPP_A_IDLE;
      endcase
    end
    if (accDone) begin
      case (job_q)
        HPP_J_POLL: if (byte_q[`HPP_IS_HOST_RX_FULL_FLAG] && !rdValid_q) begin
          job_d = HPP_J_RX;
          step_d = 2'h0;
        end else if (byte_q[`HPP_IS_HOST_TX_EMPTY_FLAG] && fifoValid) begin
          job_d = HPP_J_TX;
          step_d = 2'h0;
          word_d = fifoData;
          fifoPop = 1'b1;
        end else if (cmdValid) begin
          job_d = HPP_J_CMD;
        end
        HPP_J_RX: begin
          case (step_q)
            2'h0: rdData_d[23:16] = byte_q;
            2'h1: rdData_d[15:8] = byte_q;
            default: rdData_d[7:0] = byte_q;
          endcase
          step_d = step_q + 2'h1;
          if (step_q == 2'h2) begin
            rdValid_d = 1'b1;
            job_d = HPP_J_POLL;
          end
        end
        HPP_J_TX: begin
          step_d = step_q + 2'h1;
          if (step_q == 2'h2) begin
            job_d = HPP_J_POLL;
          end
        end
        HPP_J_CMD: begin
          cmdReady_d = 1'b1;
          job_d = HPP_J_POLL;
        end
        default: job_d = HPP_J_POLL;
      endcase
    end
    // pin drive follows the next access state so the pins come from flops
    out_d = 16'hffff;
    oe_d = 16'h3fff & {16{~rst}};
    oe_d[7:0] = 8'h00;
    if (acc_d == HPP_A_ADDR) begin
      out_d[7:0] = {cfgBase, addr_d};
      oe_d[7:0] = 8'hff;
      out_d[`HPP_PIN_AS] = 1'b0;
    end else if (acc_d == HPP_A_STRB) begin
      out_d[7:0] = data_d;
      oe_d[7:0] = {8{wr_d}};
      if (!cfgMux) begin
        out_d[`HPP_PIN_AS] = addr_d[0];
        out_d[`HPP_PIN_A1] = addr_d[1];
        out_d[`HPP_PIN_A2] = addr_d[2];
        out_d[`HPP_PIN_CS] = 1'b0;
      end
      if (cfgDual) begin
        out_d[`HPP_PIN_RW] = wr_d;
        out_d[`HPP_PIN_DS] = ~wr_d;
      end else begin
        out_d[`HPP_PIN_RW] = ~wr_d;
        out_d[`HPP_PIN_DS] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      acc_q <= HPP_A_IDLE;
      job_q <= HPP_J_INIT;
      step_q <= 2'h0;
      cnt_q <= 4'h0;
      addr_q <= 3'h0;
      wr_q <= 1'b0;
      data_q <= 8'h00;
      byte_q <= 8'h00;
      word_q <= 24'h000000;
      rdData_q <= 24'h000000;
      rdValid_q <= 1'b0;
      cmdReady_q <= 1'b0;
      out_q <= 16'hffff;
      oe_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
      job_q <= job_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      wr_q <= wr_d;
      data_q <= data_d;
      byte_q <= byte_d;
      word_q <= word_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      cmdReady_q <= cmdReady_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign rdValid = rdValid_q;
  assign rdData = rdData_q;
  assign cmdReady = cmdReady_q;
  assign pins.hostOut = out_q;
  assign pins.hostOe = oe_q;
endmodule // hpp_host
`default_nettype wire

/* testbench/hpp_props.sv */
// Purpose: pin-level checks between device and host ends
// Assumes: no gpio drive on pins 8-13
// Notes: sits beside the interface instance
`default_nettype none
module hpp_props (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] devOe,
  input wire logic [15:0] hostOut,
  input wire logic [15:0] hostOe,
  input wire logic [15:0] padLevel
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_strb;
    !padLevel[12] [*4] ##1 padLevel[12];
  endsequence
  property p_rst_off;
    disable iff (1'h0) rst |=> devOe == 16'h0;
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("pins driven in reset");
  property p_strb_len;
    $fell(padLevel[12]) |-> s_strb;
  endproperty
  a_strb_len: assert property (p_strb_len) else $error("strobe length");
  property p_gap;
    $rose(padLevel[12]) |-> padLevel[12] [*2];
  endproperty
  a_gap: assert property (p_gap) else $error("strobe gap");
  property p_hold;
    $fell(padLevel[12]) |=> ($stable(hostOe[10:0]) && $stable(hostOut[10:8])) [*3];
  endproperty
  a_hold: assert property (p_hold) else $error("address moved in strobe");
  property p_drive;
    (|devOe[7:0]) |-> !(padLevel[11] & padLevel[12]) || !$past(padLevel[11] & padLevel[12]);
  endproperty
  a_drive: assert property (p_drive) else $error("data driven outside read");
  property p_release;
    $rose(padLevel[11] & padLevel[12]) |-> ##[1:2] devOe[7:0] == 8'h0;
  endproperty
  a_release: assert property (p_release) else $error("data not released");
  property p_ctrl_in;
    devOe[12:8] == 5'h0;
  endproperty
  a_ctrl_in: assert property (p_ctrl_in) else $error("device drove host pin");
  property p_host_idle;
    $fell(rst) |-> ##[0:4] hostOe[13:8] == 6'h3f;
  endproperty
  a_host_idle: assert property (p_host_idle) else $error("host pins undriven");
endmodule // hpp_props
`default_nettype wire

/* testbench/hpp_tb.sv */
// Purpose: bench joining device and host ends of the port
// Assumes: host polls; request pins are only watched
// Notes: the first mode overfills the host fifo while the core stalls
`default_nettype none
`include "hpp_defs.svh"
module hpp_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst = 1'h1, coreWr = 1'h0, coreRd = 1'h0, cfgMux = 1'h0, cfgDual = 1'h0;
  logic wrValid = 1'h0, wrReady, rdValid, rdReady = 1'h0, cmdValid = 1'h0, cmdReady;
  logic coreCmdIrq, coreRxIrq, coreTxIrq;
  logic [2:0] coreAddr = 3'h0;
  logic [6:0] coreCmdVec;
  logic [23:0] coreWdata = 24'h0, wrData = 24'h0, coreRdata, rdData, rv;
  logic [23:0] mode [4] = '{24'h1, 24'h7, 24'hb, 24'hd};
  int num_errors = 0, n_compared = 0;
  hpp_if hpp_if_inst ();
  hpp_device hpp_device_inst (.core_clk, .rst, .coreAddr, .coreWr, .coreRd, .coreWdata,
    .coreRdata, .coreRxIrq, .coreTxIrq, .coreCmdIrq, .coreCmdVec, .pins(hpp_if_inst));
  hpp_host hpp_host_inst (.core_clk, .rst, .cfgMux, .cfgDual, .cfgBase(5'h0a), .wrValid,
    .wrReady, .wrData, .rdValid, .rdReady, .rdData, .cmdValid, .cmdVector(7'h2b), .cmdReady,
    .pins(hpp_if_inst));
  hpp_props hpp_props_inst (.core_clk, .rst, .devOe(hpp_if_inst.devOe),
    .hostOut(hpp_if_inst.hostOut), .hostOe(hpp_if_inst.hostOe),
    .padLevel(hpp_if_inst.padLevel));
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cw(logic [2:0] a, logic [23:0] d);
    coreAddr = a;
    coreWdata = d;
    coreWr = 1'h1;
    tick();
    coreWr = 1'h0;
    tick();
  endtask
  task automatic cr(logic [2:0] a);
    coreAddr = a;
    coreRd = 1'h1;
    tick();
    coreRd = 1'h0;
    tick();
    rv = coreRdata;
  endtask
  task automatic waitBit(int b);
    int k;
    k = 0;
    rv = 24'h0;
    while (rv[b] !== 1'h1 && k < 400) begin
      cr(`HPP_C_STAT);
      k++;
    end
    chk("status flag", 24'h1, {23'h0, rv[b]});
  endtask
  task automatic h2c(int n);
    int refused;
    refused = 0;
    fork
      begin
        for (int i = 0; i < n; i++) begin
          wrData = 24'h5a0300 + 24'(i);
          wrValid = 1'h1;
          while (wrReady !== 1'h1 && refused < 3000) begin
            refused++;
            tick();
          end
          tick();
        end
        wrValid = 1'h0;
      end
      begin
        // core stalls first so that, in the 22-word run, the fifo must fill and refuse
        tick(400);
        for (int i = 0; i < n; i++) begin
          waitBit(`HPP_CS_RXFULL);
          chk("core rx irq", 24'h1, {23'h0, coreRxIrq});
          cr(`HPP_C_RX);
          chk("core rx word", 24'h5a0300 + 24'(i), rv);
        end
      end
    join
    if (n > 18)
      chk("fifo refusal", 24'h1, {23'h0, refused > 0});
  endtask
  task automatic c2h(int n);
    int k;
    k = 0;
    fork
      for (int i = 0; i < n; i++) begin
        waitBit(`HPP_CS_TXEMPTY);
        cw(`HPP_C_TX, 24'ha5c000 + 24'(i));
      end
      begin
        tick(200);
        rdReady = 1'h1;
        for (int i = 0; i < n; i++) begin
          while (rdValid !== 1'h1 && k < 3000) begin
            k++;
            tick();
          end
          chk("host rx word", 24'ha5c000 + 24'(i), rdData);
          tick();
        end
        rdReady = 1'h0;
      end
    join
  endtask
  task automatic cmd();
    int k;
    k = 0;
    cw(`HPP_C_CTRL, 24'h4);
    cmdValid = 1'h1;
    while (cmdReady !== 1'h1 && k < 400) begin
      k++;
      tick();
    end
    cmdValid = 1'h0;
    waitBit(`HPP_CS_CMDPEND);
    chk("command vector", 24'h2b, {17'h0, coreCmdVec});
    chk("command irq", 24'h1, {23'h0, coreCmdIrq});
    cw(`HPP_C_STAT, 24'h4);
    chk("command irq", 24'h0, {23'h0, coreCmdIrq});
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(20);
    chk("reset pad drive", 24'h0, {8'h0, hpp_if_inst.devOe});
    rst = 1'h0;
    cw(`HPP_C_PINS, 24'h1);
    cw(`HPP_C_BASE, 24'h0a);
    cr(`HPP_C_STAT);
    chk("core status", 24'h2, rv);
    cmd();
    foreach (mode[m]) begin
      // the host has no idle handshake, so both ends restart together in the new mode
      rst = 1'h1;
      cfgMux = mode[m][1];
      cfgDual = mode[m][2];
      tick(2);
      chk("reset pad drive", 24'h0, {8'h0, hpp_if_inst.devOe});
      rst = 1'h0;
      cw(`HPP_C_PINS, mode[m]);
      cw(`HPP_C_BASE, 24'h0a);
      cw(`HPP_C_CTRL, 24'h3);
      chk("core tx irq", 24'h1, {23'h0, coreTxIrq});
      tick(60);
      chk("request pins", 24'h2, {22'h0, hpp_if_inst.padLevel[15:14]});
      h2c(m == 0 ? 22 : 3);
      c2h(3);
    end
    cw(`HPP_C_PINS, 24'h0);
    cw(`HPP_C_GDIR, 24'hc000);
    cw(`HPP_C_GVAL, 24'h8000);
    chk("gpio pins", 24'h2, {22'h0, hpp_if_inst.padLevel[15:14]});
    finish_test();
  end
  initial begin
    tick(40000);
    num_errors++;
    finish_test();
  end
endmodule // hpp_tb
`default_nettype wire
